// [mps_pkg.sv]
/*
 package for the mac-facing mii / serial interface: clock rates, divider
 half periods, strap timing, 5b code groups, event word layout, state types.
 assumes clk_sys runs at SYS_CLK_HZ.
*/
package mps_pkg;
   // clock rates
   localparam int SYS_CLK_HZ = 100_000_000;
   localparam int MII_100M_CLK_HZ = 25_000_000;
   localparam int MII_10M_CLK_HZ = 2_500_000;
   localparam int SERIAL_CLK_HZ = 10_000_000;
   localparam logic [4:0] HALF_100M = 5'(SYS_CLK_HZ / (2 * MII_100M_CLK_HZ));
   localparam logic [4:0] HALF_10M = 5'(SYS_CLK_HZ / (2 * MII_10M_CLK_HZ));
   localparam logic [4:0] HALF_SERIAL = 5'(SYS_CLK_HZ / (2 * SERIAL_CLK_HZ));
   localparam logic [4:0] DIV_STEP = 5'h01;

   // strap capture window after reset release, in clk_sys cycles
   localparam logic [3:0] STRAP_WAIT = 4'hA;
   localparam logic [3:0] STRAP_STEP = 4'h1;

   // serial mode bit position within a nibble
   localparam logic [1:0] SERIAL_FIRST_BIT = 2'h0;
   localparam logic [1:0] SERIAL_LAST_BIT = 2'h3;
   localparam logic [1:0] SERIAL_STEP = 2'h1;

   // control code groups
   localparam logic [4:0] SYM_J = 5'h18;
   localparam logic [4:0] SYM_K = 5'h11;
   localparam logic [4:0] SYM_T = 5'h0D;
   localparam logic [4:0] SYM_R = 5'h07;
   localparam logic [4:0] SYM_IDLE = 5'h1F;

   // event word {kind, err, nibble}
   localparam int EV_NIB_LSB = 0;
   localparam int EV_ERR_BIT = 4;
   localparam int EV_KIND_LSB = 5;
   localparam logic [1:0] EV_DATA = 2'h1;
   localparam logic [1:0] EV_END = 2'h2;

   // three-level line codes
   localparam logic [1:0] MLT_ZERO = 2'h0;
   localparam logic [1:0] MLT_POS = 2'h1;
   localparam logic [1:0] MLT_NEG = 2'h3;

   typedef enum logic [3:0] {
      MPS_LRX_IDLE = 4'h1,
      MPS_LRX_WAIT_K = 4'h2,
      MPS_LRX_FRAME = 4'h4,
      MPS_LRX_WAIT_R = 4'h8
   } mps_lrx_state_t;

   typedef enum logic [3:0] {
      MPS_TX_IDLE = 4'h1,
      MPS_TX_SEND_K = 4'h2,
      MPS_TX_DATA = 4'h4,
      MPS_TX_SEND_R = 4'h8
   } mps_tx_state_t;

   // 4b to 5b data code groups
   function automatic logic [4:0] mps_enc_4b5b(input logic [3:0] nib);
      logic [4:0] c;
      c = 5'h1E;
      case (nib)
         4'h0: c = 5'h1E;
         4'h1: c = 5'h09;
         4'h2: c = 5'h14;
         4'h3: c = 5'h15;
         4'h4: c = 5'h0A;
         4'h5: c = 5'h0B;
         4'h6: c = 5'h0E;
         4'h7: c = 5'h0F;
         4'h8: c = 5'h12;
         4'h9: c = 5'h13;
         4'hA: c = 5'h16;
         4'hB: c = 5'h17;
         4'hC: c = 5'h1A;
         4'hD: c = 5'h1B;
         4'hE: c = 5'h1C;
         default: c = 5'h1D;
      endcase
      return c;
   endfunction
endpackage

// [mps_sync3.sv]
/*
 three-stage synchroniser; the output follows once stages two and three agree.
 assumes inputs are asynchronous levels or toggles held for several cycles.
*/
`timescale 1ns/1ns
module mps_sync3 #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // levels
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] ff1_reg;
   logic [WIDTH-1:0] ff2_reg;
   logic [WIDTH-1:0] ff3_reg;
   logic [WIDTH-1:0] dout_next;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         assign dout_next[g] = (ff2_reg[g] == ff3_reg[g]) ? ff3_reg[g] : dout[g];
      end
   endgenerate

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ff1_reg <= '0;
         ff2_reg <= '0;
         ff3_reg <= '0;
         dout <= '0;
      end else begin
         ff1_reg <= din;
         ff2_reg <= ff1_reg;
         ff3_reg <= ff2_reg;
         dout <= dout_next;
      end
   end
endmodule // mps_sync3

// [mps_line_rx.sv]
/*
 line-side receive: checks 5b code groups, finds start and end delimiters,
 decodes data and posts one event word per nibble with a toggle.
 assumes events are spaced at least two line_clk cycles apart.
*/
`timescale 1ns/1ns
module mps_line_rx (
   // line clock and reset
   input wire logic line_clk,
   input wire logic arst_n,
   // received code groups
   input wire logic [4:0] code,
   input wire logic code_valid,
   // events toward the system clock
   output logic [6:0] event_word,
   output logic event_toggle,
   output logic line_busy
);
   mps_pkg::mps_lrx_state_t state_reg;
   mps_pkg::mps_lrx_state_t state_next;
   logic emit;
   logic [6:0] emit_word;
   logic dec_hit;
   logic [3:0] dec_nib;

   // data code group lookup
   always_comb begin
      dec_hit = 1'b0;
      dec_nib = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (code == mps_pkg::mps_enc_4b5b(4'(i))) begin
            dec_hit = 1'b1;
            dec_nib = 4'(i);
         end
      end
   end

   always_comb begin
      state_next = state_reg;
      emit = 1'b0;
      emit_word = 7'h00;
      if (code_valid) begin
         case (state_reg)
            mps_pkg::MPS_LRX_IDLE: begin
               if (code == mps_pkg::SYM_J) begin
                  state_next = mps_pkg::MPS_LRX_WAIT_K;
               end
            end
            mps_pkg::MPS_LRX_WAIT_K: begin
               if (code == mps_pkg::SYM_K) begin
                  state_next = mps_pkg::MPS_LRX_FRAME;
               end else begin
                  emit = 1'b1;
                  emit_word = {mps_pkg::EV_END, 1'b1, 4'h0};
                  state_next = mps_pkg::MPS_LRX_IDLE;
               end
            end
            mps_pkg::MPS_LRX_FRAME: begin
               if (dec_hit) begin
                  emit = 1'b1;
                  emit_word = {mps_pkg::EV_DATA, 1'b0, dec_nib};
               end else if (code == mps_pkg::SYM_T) begin
                  state_next = mps_pkg::MPS_LRX_WAIT_R;
               end else if (code == mps_pkg::SYM_IDLE) begin
                  emit = 1'b1;
                  emit_word = {mps_pkg::EV_END, 1'b1, 4'h0};
                  state_next = mps_pkg::MPS_LRX_IDLE;
               end else begin
                  emit = 1'b1;
                  emit_word = {mps_pkg::EV_DATA, 1'b1, 4'h0};
               end
            end
            mps_pkg::MPS_LRX_WAIT_R: begin
               emit = 1'b1;
               emit_word = {mps_pkg::EV_END, code != mps_pkg::SYM_R, 4'h0};
               state_next = mps_pkg::MPS_LRX_IDLE;
            end
            default: begin
               state_next = mps_pkg::MPS_LRX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge line_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= mps_pkg::MPS_LRX_IDLE;
         event_word <= 7'h00;
         event_toggle <= 1'b0;
         line_busy <= 1'b0;
      end else begin
         state_reg <= state_next;
         line_busy <= state_next != mps_pkg::MPS_LRX_IDLE;
         if (emit) begin
            event_word <= emit_word;
            event_toggle <= ~event_toggle;
         end
      end
   end
endmodule // mps_line_rx

// [mps_mii_sni.sv]
/*
 mac-facing data interface of a 10/100 physical-layer device: nibble mode
 at 100 or 10 Mbps, seven-wire serial mode at 10 Mbps, strap capture,
 transmit 4b5b and three-level coding, receive presentation and carrier.
 assumes clk_sys is the device reference; line_clk clocks the line receiver.
*/
`timescale 1ns/1ns
// Behaviour
// - transmit clock to the mac runs continuously and times transmit data.
// - receive clock runs continuously, 25 MHz at 100 Mbps, 2.5 MHz at 10 Mbps nibble mode, 10 MHz in serial mode.
// - collision output high while a collision is seen, low otherwise.
// - carrier sense high while the medium is busy, low when idle.
// - receive data valid high during packet data, dropped at packet end.
// - receive data is a nibble in nibble mode, one bit in serial mode, driven in step with the receive clock.
// - receive error goes high on a 5b decode error inside a frame or its delimiters; bad codes while idle are ignored.
// - shared error pin is sampled after reset to pick fiber or twisted pair.
// - management clock is accepted although asynchronous to data clocks.
// - serial mode runs at 10 Mbps only, one data bit each way.
// - in serial mode the receive clock is realigned to incoming data.
// - in serial mode the device generates the transmit clock.
// - all timing derives from one reference clock; the line receiver here runs on line_clk instead.
// - 100 Mbps twisted-pair transmit uses three-level coding.
// - interface select strap picks nibble mode high, serial mode low.
// - speed strap picks 100 Mbps high, 10 Mbps low.
module mps_mii_sni (
   // clocks and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic line_clk,
   // mac transmit
   input wire logic mac_tx_en,
   input wire logic [3:0] mac_txd,
   output logic mac_tx_clk,
   // mac receive
   output logic mac_rx_clk,
   output logic mac_rx_dv,
   output logic [3:0] mac_rxd,
   output logic mac_crs,
   output logic mac_col,
   // shared receive error and media strap pin
   input wire logic rx_error_in,
   output logic rx_error_out,
   output logic rx_error_oe,
   // configuration straps
   input wire logic parallel_serial_interface_select_pin,
   input wire logic speed_select_pin,
   // latched configuration
   output logic fiber_media_select,
   output logic parallel_serial_interface_select,
   output logic speed_100_select,
   // line receive, on line_clk
   input wire logic [4:0] line_rx_code,
   input wire logic line_rx_code_valid,
   // line transmit
   output logic [4:0] line_tx_code,
   output logic [9:0] line_tx_mlt3,
   output logic line_tx_strobe,
   // management clock and data
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mgmt_bit,
   output logic mgmt_bit_valid
);
   // three-level code for five bits, first bit in the low pair
   function automatic logic [11:0] mps_mlt3(input logic [4:0] code, input logic [1:0] phase);
      logic [1:0] p;
      logic [9:0] lv;
      p = phase;
      lv = 10'h000;
      for (int i = 0; i < 5; i++) begin
         p = p + {1'b0, code[i]};
         case (p)
            2'h1: lv[2*i +: 2] = mps_pkg::MLT_POS;
            2'h3: lv[2*i +: 2] = mps_pkg::MLT_NEG;
            default: lv[2*i +: 2] = mps_pkg::MLT_ZERO;
         endcase
      end
      return {p, lv};
   endfunction

   logic [6:0] event_word;
   logic event_toggle;
   logic line_busy;
   logic [6:0] sync_out;
   logic s_toggle, s_busy, s_mdc, s_mdio, s_rxer_pin, s_if_pin, s_speed_pin;

   logic [3:0] strap_cnt_reg;
   logic straps_done_reg;
   logic fiber_reg, mii_mode_reg, speed100_reg;

   logic [4:0] tx_cnt_reg, rx_cnt_reg;
   logic txc_reg, rxc_reg;
   logic toggle_prev_reg, busy_prev_reg, mdc_prev_reg;

   logic [6:0] hold_word_reg;
   logic hold_valid_reg;
   logic dv_reg, rxer_reg;
   logic [3:0] rxd_reg, rx_sh_reg;
   logic [1:0] rx_bit_cnt_reg;

   logic [3:0] tx_sh_reg;
   logic [1:0] tx_bit_cnt_reg, mlt_phase_reg;
   mps_pkg::mps_tx_state_t tx_state_reg, tx_state_next;
   logic [4:0] tx_code_reg, tx_code_next;
   logic [9:0] tx_mlt3_reg;
   logic tx_strobe_reg;
   logic crs_reg, col_reg, mgmt_bit_reg, mgmt_valid_reg;

   mps_line_rx u_line_rx (
      .line_clk(line_clk),
      .arst_n(arst_n),
      .code(line_rx_code),
      .code_valid(line_rx_code_valid),
      .event_word(event_word),
      .event_toggle(event_toggle),
      .line_busy(line_busy)
   );

   mps_sync3 #(.WIDTH(7)) u_sync (
      .clk(clk_sys),
      .arst_n(arst_n),
      .din({event_toggle, line_busy, mdc, mdio_in, rx_error_in, parallel_serial_interface_select_pin,
            speed_select_pin}),
      .dout(sync_out)
   );
   assign {s_toggle, s_busy, s_mdc, s_mdio, s_rxer_pin, s_if_pin, s_speed_pin} = sync_out;

   // strap capture after reset release
   wire strap_latch = !straps_done_reg && (strap_cnt_reg == mps_pkg::STRAP_WAIT);
   wire serial_mode = !mii_mode_reg;
   wire speed100_eff = speed100_reg && mii_mode_reg;

   // clock dividers from the reference
   wire [4:0] half_sel = serial_mode ? mps_pkg::HALF_SERIAL :
                         (speed100_eff ? mps_pkg::HALF_100M : mps_pkg::HALF_10M);
   wire [4:0] half_m1 = half_sel - mps_pkg::DIV_STEP;
   wire tx_tick = tx_cnt_reg >= half_m1;
   wire rx_tick = rx_cnt_reg >= half_m1;
   wire busy_rise = s_busy && !busy_prev_reg;
   wire rx_realign = serial_mode && busy_rise;
   wire tx_rise = tx_tick && !txc_reg;
   wire rx_fall = rx_tick && rxc_reg && !rx_realign;

   // receive hand-off from the line clock
   wire capture = s_toggle != toggle_prev_reg;
   wire nib_point = rx_fall && straps_done_reg && (mii_mode_reg || rx_bit_cnt_reg == mps_pkg::SERIAL_FIRST_BIT);
   wire [1:0] hold_kind = hold_word_reg[mps_pkg::EV_KIND_LSB +: 2];
   wire [3:0] hold_nib = hold_word_reg[mps_pkg::EV_NIB_LSB +: 4];
   wire hold_err = hold_word_reg[mps_pkg::EV_ERR_BIT];
   wire is_data = hold_valid_reg && hold_kind == mps_pkg::EV_DATA;
   wire is_end = hold_valid_reg && hold_kind == mps_pkg::EV_END;
   wire dv_next = is_data ? 1'b1 : (is_end ? 1'b0 : dv_reg);
   wire [3:0] load_nib = is_data ? hold_nib : 4'h0;
   wire [3:0] nib_out = is_data ? hold_nib : ((is_end || !dv_reg) ? 4'h0 : rxd_reg);
   wire serial_bit_next = nib_point ? load_nib[0] : rx_sh_reg[1];
   wire [3:0] rxd_next = mii_mode_reg ? nib_out : {3'h0, serial_bit_next};
   wire serial_receive_bit = rxd_reg[0];

   // transmit sampling and coding
   wire tx_samp = tx_rise && straps_done_reg;
   wire serial_transmit_bit = mac_txd[0];
   wire sym_point = tx_samp && (mii_mode_reg || tx_bit_cnt_reg == mps_pkg::SERIAL_LAST_BIT);
   wire [3:0] sym_nib = mii_mode_reg ? mac_txd : {serial_transmit_bit, tx_sh_reg[3:1]};
   wire tx_active = tx_state_reg != mps_pkg::MPS_TX_IDLE;
   wire mlt_on = speed100_eff && !fiber_reg;
   wire [11:0] mlt_res = mps_mlt3(tx_code_next, mlt_phase_reg);
   wire mdc_rise = s_mdc && !mdc_prev_reg;

   always_comb begin
      tx_state_next = tx_state_reg;
      tx_code_next = mps_pkg::SYM_IDLE;
      case (tx_state_reg)
         mps_pkg::MPS_TX_IDLE: begin
            if (mac_tx_en) begin
               tx_code_next = mps_pkg::SYM_J;
               tx_state_next = mps_pkg::MPS_TX_SEND_K;
            end
         end
         mps_pkg::MPS_TX_SEND_K: begin
            tx_code_next = mps_pkg::SYM_K;
            tx_state_next = mps_pkg::MPS_TX_DATA;
         end
         mps_pkg::MPS_TX_DATA: begin
            if (mac_tx_en) begin
               tx_code_next = mps_pkg::mps_enc_4b5b(sym_nib);
            end else begin
               tx_code_next = mps_pkg::SYM_T;
               tx_state_next = mps_pkg::MPS_TX_SEND_R;
            end
         end
         mps_pkg::MPS_TX_SEND_R: begin
            tx_code_next = mps_pkg::SYM_R;
            tx_state_next = mps_pkg::MPS_TX_IDLE;
         end
         default: begin
            tx_state_next = mps_pkg::MPS_TX_IDLE;
         end
      endcase
   end

   // straps
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         strap_cnt_reg <= 4'h0;
         straps_done_reg <= 1'b0;
         fiber_reg <= 1'b0;
         mii_mode_reg <= 1'b1;
         speed100_reg <= 1'b1;
      end else if (strap_latch) begin
         straps_done_reg <= 1'b1;
         fiber_reg <= s_rxer_pin;
         mii_mode_reg <= s_if_pin;
         speed100_reg <= s_speed_pin;
      end else if (!straps_done_reg) begin
         strap_cnt_reg <= strap_cnt_reg + mps_pkg::STRAP_STEP;
      end
   end

   // clocks toward the mac
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tx_cnt_reg <= 5'h00;
         rx_cnt_reg <= 5'h00;
         txc_reg <= 1'b0;
         rxc_reg <= 1'b0;
      end else begin
         tx_cnt_reg <= tx_tick ? 5'h00 : tx_cnt_reg + mps_pkg::DIV_STEP;
         txc_reg <= tx_tick ? ~txc_reg : txc_reg;
         rx_cnt_reg <= (tx_tick && !serial_mode) || rx_realign || (serial_mode && rx_tick) ? 5'h00 :
                       rx_cnt_reg + mps_pkg::DIV_STEP;
         rxc_reg <= rx_realign ? 1'b0 : (rx_tick ? ~rxc_reg : rxc_reg);
      end
   end

   // receive presentation
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         toggle_prev_reg <= 1'b0;
         busy_prev_reg <= 1'b0;
         hold_word_reg <= 7'h00;
         hold_valid_reg <= 1'b0;
         dv_reg <= 1'b0;
         rxer_reg <= 1'b0;
         rxd_reg <= 4'h0;
         rx_sh_reg <= 4'h0;
         rx_bit_cnt_reg <= 2'h0;
      end else begin
         toggle_prev_reg <= s_toggle;
         busy_prev_reg <= s_busy;
         if (capture) begin
            hold_word_reg <= event_word;
         end
         hold_valid_reg <= capture || (hold_valid_reg && !nib_point);
         if (rx_fall) begin
            rxd_reg <= rxd_next;
            rx_sh_reg <= nib_point ? load_nib : {1'b0, rx_sh_reg[3:1]};
            rx_bit_cnt_reg <= serial_mode ? rx_bit_cnt_reg + mps_pkg::SERIAL_STEP : mps_pkg::SERIAL_FIRST_BIT;
         end
         if (nib_point) begin
            dv_reg <= dv_next;
            rxer_reg <= hold_valid_reg && hold_err;
         end
      end
   end

   // transmit coding
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tx_state_reg <= mps_pkg::MPS_TX_IDLE;
         tx_sh_reg <= 4'h0;
         tx_bit_cnt_reg <= 2'h0;
         mlt_phase_reg <= 2'h0;
         tx_code_reg <= mps_pkg::SYM_IDLE;
         tx_mlt3_reg <= 10'h000;
         tx_strobe_reg <= 1'b0;
      end else begin
         tx_strobe_reg <= sym_point;
         if (tx_samp) begin
            tx_sh_reg <= {serial_transmit_bit, tx_sh_reg[3:1]};
            tx_bit_cnt_reg <= serial_mode ? tx_bit_cnt_reg + mps_pkg::SERIAL_STEP : mps_pkg::SERIAL_FIRST_BIT;
         end
         if (sym_point) begin
            tx_state_reg <= tx_state_next;
            tx_code_reg <= tx_code_next;
            tx_mlt3_reg <= mlt_on ? mlt_res[9:0] : 10'h000;
            if (mlt_on) begin
               mlt_phase_reg <= mlt_res[11:10];
            end
         end
      end
   end

   // carrier, collision, shared pin, management sampling
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         crs_reg <= 1'b0;
         col_reg <= 1'b0;
         mdc_prev_reg <= 1'b0;
         mgmt_bit_reg <= 1'b0;
         mgmt_valid_reg <= 1'b0;
         rx_error_out <= 1'b0;
         rx_error_oe <= 1'b0;
      end else begin
         crs_reg <= s_busy || tx_active;
         col_reg <= s_busy && tx_active;
         mdc_prev_reg <= s_mdc;
         mgmt_valid_reg <= mdc_rise;
         if (mdc_rise) begin
            mgmt_bit_reg <= s_mdio;
         end
         rx_error_out <= rxer_reg;
         rx_error_oe <= straps_done_reg;
      end
   end

   assign mac_tx_clk = txc_reg;
   assign mac_rx_clk = rxc_reg;
   assign mac_rx_dv = dv_reg;
   assign mac_rxd = rxd_reg;
   assign mac_crs = crs_reg;
   assign mac_col = col_reg;
   assign fiber_media_select = fiber_reg;
   assign parallel_serial_interface_select = mii_mode_reg;
   assign speed_100_select = speed100_reg;
   assign line_tx_code = tx_code_reg;
   assign line_tx_mlt3 = tx_mlt3_reg;
   assign line_tx_strobe = tx_strobe_reg;
   assign mgmt_bit = mgmt_bit_reg;
   assign mgmt_bit_valid = mgmt_valid_reg;
endmodule // mps_mii_sni

// [mps_mii_sni_props.sv]
/*
 checker for the mii / serial ports.
 assumes straps held from reset release.
*/
`timescale 1ns/1ns
module mps_mii_sni_props (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // mac side
   input wire logic mac_tx_clk,
   input wire logic mac_rx_clk,
   input wire logic mac_rx_dv,
   input wire logic [3:0] mac_rxd,
   input wire logic mac_crs,
   input wire logic mac_col,
   // straps and line
   input wire logic rx_error_oe,
   input wire logic fiber_media_select,
   input wire logic parallel_serial_interface_select,
   input wire logic speed_100_select,
   input wire logic [9:0] line_tx_mlt3,
   input wire logic line_tx_strobe
);
   logic [5:0] settle_reg;
   wire settled = settle_reg == 6'h3F;
   wire nib = settled && parallel_serial_interface_select;
   wire [2:0] straps = {fiber_media_select, parallel_serial_interface_select, speed_100_select};
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         settle_reg <= 6'h00;
      end else if (rx_error_oe && !settled) begin
         settle_reg <= settle_reg + 6'h01;
      end
   end
   chk_rxd_zero_idle: assert property (parallel_serial_interface_select && !mac_rx_dv |-> mac_rxd == 4'h0)
      else $error("rxd not zero");
   chk_col_has_crs: assert property (mac_col |-> mac_crs)
      else $error("col without crs");
   chk_rx_rate_fast: assert property (nib && speed_100_select && $rose(mac_rx_clk) |->
      ##1 !$rose(mac_rx_clk) [*3] ##1 $rose(mac_rx_clk))
      else $error("rx clk period");
   chk_tx_rate_fast: assert property (nib && speed_100_select && $rose(mac_tx_clk) |->
      ##1 !$rose(mac_tx_clk) [*3] ##1 $rose(mac_tx_clk))
      else $error("tx clk period");
   chk_rx_rate_slow: assert property (nib && !speed_100_select && $rose(mac_rx_clk) |->
      ##20 $fell(mac_rx_clk) ##20 $rose(mac_rx_clk))
      else $error("rx clk slow period");
   chk_tx_rate_slow: assert property (nib && !speed_100_select && $rose(mac_tx_clk) |->
      ##20 $fell(mac_tx_clk) ##20 $rose(mac_tx_clk))
      else $error("tx clk slow period");
   chk_tx_rate_serial: assert property (settled && !parallel_serial_interface_select && $rose(mac_tx_clk) |->
      ##5 $fell(mac_tx_clk) ##5 $rose(mac_tx_clk))
      else $error("serial tx clk period");
   chk_strobe_after_rise: assert property (line_tx_strobe |-> mac_tx_clk && !$past(mac_tx_clk))
      else $error("strobe not after tx clk rise");
   chk_mlt_quiet: assert property (settled && (fiber_media_select || !speed_100_select) |->
      line_tx_mlt3 == 10'h000)
      else $error("mlt3 active");
   chk_oe_holds: assert property (!$fell(rx_error_oe))
      else $error("oe dropped");
   chk_straps_hold: assert property (rx_error_oe && $past(rx_error_oe) |-> $stable(straps))
      else $error("straps changed");
endmodule // mps_mii_sni_props

bind mps_mii_sni mps_mii_sni_props chk (.*);

// [mps_mac_model.sv]
/*
 mac transmit model: one nibble after each tx clock rise.
 assumes mac_tx_clk is a clk_sys flop output.
*/
`timescale 1ns/1ns
module mps_mac_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // bench request
   input wire logic go,
   input wire logic [3:0] nib,
   output logic taken,
   // mac transmit pins
   input wire logic mac_tx_clk,
   output logic mac_tx_en,
   output logic [3:0] mac_txd
);
   logic clk_d_reg;
   wire launch = mac_tx_clk && !clk_d_reg;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         clk_d_reg <= 1'h0;
         taken <= 1'h0;
         mac_tx_en <= 1'h0;
         mac_txd <= 4'h0;
      end else begin
         clk_d_reg <= mac_tx_clk;
         taken <= launch && go;
         if (launch) begin
            mac_tx_en <= go;
            mac_txd <= go ? nib : ~mac_txd;
         end
      end
   end
endmodule // mps_mac_model

// [tb.sv]
/*
 bench: strap configs, tx and rx frames, collision.
 assumes design, checker and mac model compiled first.
*/
`timescale 1ns/1ns
module tb;
   logic clk_sys = 1'h0, line_clk = 1'h0, arst_n = 1'h0, mdc = 1'h0, mdio_in = 1'h0;
   logic go = 1'h0, code_valid = 1'h0, iface_pin = 1'h1, speed_pin = 1'h1, fiber_pin = 1'h0;
   logic [3:0] nib = 4'h0;
   logic [4:0] code = 5'h1F;
   logic taken, mac_tx_en, mac_tx_clk, mac_rx_clk, mac_rx_dv, mac_crs, mac_col, rx_error_out, rx_error_oe;
   logic fiber_sel, iface_sel, speed_sel, line_tx_strobe, mgmt_bit, mgmt_bit_valid;
   logic [3:0] mac_txd, mac_rxd;
   logic [4:0] line_tx_code;
   logic [9:0] line_tx_mlt3;
   logic [31:0] seed = 32'h18a8339c;
   int num_errors = 0, checked = 0, cyc = 0;
   logic err_seen, col_seen, mlt_seen;
   logic [4:0] got_q[$];
   logic [3:0] rx_q[$];
   wire err_wire = rx_error_oe ? rx_error_out : fiber_pin;
   localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
   localparam logic [2:0] CFG [4] = '{3'h6, 3'h7, 3'h4, 3'h0};
   mps_mii_sni dut (.clk_sys(clk_sys), .arst_n(arst_n), .line_clk(line_clk), .mac_tx_en(mac_tx_en),
      .mac_txd(mac_txd), .mac_tx_clk(mac_tx_clk), .mac_rx_clk(mac_rx_clk), .mac_rx_dv(mac_rx_dv),
      .mac_rxd(mac_rxd), .mac_crs(mac_crs), .mac_col(mac_col), .rx_error_in(err_wire),
      .rx_error_out(rx_error_out), .rx_error_oe(rx_error_oe), .parallel_serial_interface_select_pin(iface_pin),
      .speed_select_pin(speed_pin), .fiber_media_select(fiber_sel), .parallel_serial_interface_select(iface_sel),
      .speed_100_select(speed_sel), .line_rx_code(code), .line_rx_code_valid(code_valid),
      .line_tx_code(line_tx_code), .line_tx_mlt3(line_tx_mlt3), .line_tx_strobe(line_tx_strobe), .mdc(mdc),
      .mdio_in(mdio_in), .mgmt_bit(mgmt_bit), .mgmt_bit_valid(mgmt_bit_valid));
   mps_mac_model mac (.clk_sys(clk_sys), .arst_n(arst_n), .go(go), .nib(nib), .taken(taken),
      .mac_tx_clk(mac_tx_clk), .mac_tx_en(mac_tx_en), .mac_txd(mac_txd));
   initial forever #5 clk_sys = ~clk_sys;
   initial begin
      #7;
      forever #16 line_clk = ~line_clk;
   end
   always #200 mdc = ~mdc;
   always @(negedge mdc) mdio_in <= seed[cyc % 32];
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'h0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      if (num_errors == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (line_tx_strobe && line_tx_code !== 5'h1F) got_q.push_back(line_tx_code);
      if (mac_col) col_seen = 1'h1;
      if (rx_error_out) err_seen = 1'h1;
      if (line_tx_mlt3 !== 10'h000) mlt_seen = 1'h1;
      if (mgmt_bit_valid) check("mgmt_bit", mgmt_bit, mdio_in);
      if (cyc == 20000) begin
         num_errors++;
         print_verdict();
      end
   end
   always @(posedge mac_rx_clk) if (mac_rx_dv) rx_q.push_back(mac_rxd);
   task automatic line_send(input logic [4:0] c);
      @(posedge line_clk);
      code <= c;
      code_valid <= 1'h1;
      @(posedge line_clk);
      code <= ~c;
      code_valid <= 1'h0;
   endtask
   task automatic tx_frame();
      int n;
      logic [3:0] sent[$];
      n = 0;
      nib <= seed[3:0];
      go <= 1'h1;
      while (n < 10) begin
         @(posedge clk_sys);
         if (taken === 1'h1) begin
            sent.push_back(nib);
            seed = lfsr(seed);
            nib <= seed[3:0];
            n++;
            if (n == 10) go <= 1'h0;
         end
      end
      repeat (400) @(posedge clk_sys);
      check("tx count", got_q.size(), 12);
      for (int i = 0; i < 12; i++) begin
         check("tx code", got_q[i], i < 2 ? (i ? 5'h11 : 5'h18) : i > 9 ? (i > 10 ? 5'h07 : 5'h0D) : ENC[sent[i]]);
      end
   endtask
   task automatic rx_frame(input logic bad);
      logic [3:0] d[$];
      int k;
      line_send(5'h18);
      line_send(5'h11);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         d.push_back((bad && i == 4) ? 4'h0 : seed[7:4]);
         line_send((bad && i == 4) ? 5'h00 : ENC[seed[7:4]]);
      end
      line_send(5'h0D);
      line_send(5'h07);
      repeat (8) @(posedge line_clk);
      k = 0;
      foreach (rx_q[i]) if (k < 8 && rx_q[i] === d[k]) k++;
      check("rx nibbles", k, 8);
      check("rx dv end", mac_rx_dv, 1'h0);
   endtask
   initial begin
      foreach (CFG[c]) begin
         arst_n <= 1'h0;
         {iface_pin, speed_pin, fiber_pin} <= CFG[c];
         repeat (8) @(posedge clk_sys);
         arst_n <= 1'h1;
         repeat (30) @(posedge clk_sys);
         check("fiber", fiber_sel, CFG[c][0]);
         check("iface", iface_sel, CFG[c][2]);
         check("speed", speed_sel, CFG[c][1]);
         check("error oe", rx_error_oe, 1'h1);
         err_seen = 1'h0;
         col_seen = 1'h0;
         mlt_seen = 1'h0;
         got_q.delete();
         rx_q.delete();
         fork
            if (CFG[c][2]) tx_frame();
            if (CFG[c][1]) rx_frame(c == 1);
         join
         repeat (300) @(posedge clk_sys);
         check("crs idle", mac_crs, 1'h0);
         check("mlt3 active", mlt_seen, CFG[c][1] && !CFG[c][0]);
         check("collision", col_seen, CFG[c][1]);
         check("rx error", err_seen, c == 1);
      end
      print_verdict();
   end
endmodule // tb
